// file: shared/aeu_pkg.sv
// constants and types shared by the accumulator extract unit
package aeu_pkg;

  // instruction field positions
  localparam int OPC_MAJ_HI = 31;
  localparam int OPC_MAJ_LO = 26;
  localparam int SHAMT_HI = 25;
  localparam int SHAMT_LO = 21;
  localparam int DEST_HI = 20;
  localparam int DEST_LO = 16;
  localparam int ZERO_HI = 15;
  localparam int ZERO_LO = 13;
  localparam int ACSEL_HI = 12;
  localparam int ACSEL_LO = 11;
  localparam int SUBOP_HI = 10;
  localparam int SUBOP_LO = 6;
  localparam int FUNC_HI = 5;
  localparam int FUNC_LO = 0;

  // opcode values
  localparam logic [5:0] EXT_MAJOR_OPCODE = 6'h1F;
  localparam logic [5:0] EXT_FUNC_CODE = 6'h38;
  localparam logic [2:0] ZERO_FIELD = 3'h0;
  localparam logic [4:0] SUB_WORD_PLAIN = 5'h00;
  localparam logic [4:0] SUB_WORD_RND = 5'h04;
  localparam logic [4:0] SUB_WORD_RSAT = 5'h06;
  localparam logic [4:0] SUB_HALF_SAT = 5'h0E;
  localparam logic [4:0] SUB_WORDV_PLAIN = 5'h01;
  localparam logic [4:0] SUB_WORDV_RND = 5'h05;
  localparam logic [4:0] SUB_WORDV_RSAT = 5'h07;

  // saturation limits
  localparam logic [31:0] Q31_MAX = 32'h7FFFFFFF;
  localparam logic [31:0] Q31_MIN = 32'h80000000;
  localparam logic [31:0] HALF_MAX = 32'h00007FFF;
  localparam logic [31:0] HALF_MIN = 32'hFFFF8000;
  localparam logic [32:0] HIGH_ZEROS = 33'h000000000;
  localparam logic [32:0] HIGH_ONES = 33'h1FFFFFFFF;

  // position of the sticky flag in the control register
  localparam int OVF_FLAG_BIT = 23;

  // reset values
  localparam logic [31:0] ACC_RESET = 32'h00000000;
  localparam logic [63:0] RES_RESET = 64'h0000000000000000;

  typedef enum logic [2:0] {
    AEU_OP_NONE,
    AEU_OP_WORD,
    AEU_OP_WORD_RND,
    AEU_OP_WORD_SAT,
    AEU_OP_HALF
  } aeu_op_t;

endpackage : aeu_pkg

// file: shared/aeu_acc_if.sv
// accumulator bank access between the extract datapath and its bank
`timescale 1ns/1ps
`default_nettype none
interface aeu_acc_if;
  logic wrEn;
  logic [1:0] wrSel;
  logic [31:0] wrHi;
  logic [31:0] wrLo;
  logic [1:0] rdSel;
  logic [31:0] rdHi;
  logic [31:0] rdLo;

  modport bank (
    input wrEn, wrSel, wrHi, wrLo, rdSel,
    output rdHi, rdLo
  );

  modport user (
    output wrEn, wrSel, wrHi, wrLo, rdSel,
    input rdHi, rdLo
  );
endinterface : aeu_acc_if
`default_nettype wire

// file: hdl/aeu_acc_bank.sv
// four 64-bit accumulators held as upper and bottom halves
`timescale 1ns/1ps
`default_nettype none
module aeu_acc_bank
  import aeu_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  aeu_acc_if.bank acc
);

  logic [31:0] upperHalf_q [4];
  logic [31:0] upperHalf_d [4];
  logic [31:0] bottomHalf_q [4];
  logic [31:0] bottomHalf_d [4];

  // only the pipeline's own write port changes an accumulator
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      upperHalf_d[i] = upperHalf_q[i];
      bottomHalf_d[i] = bottomHalf_q[i];
    end
    if (acc.wrEn) begin
      upperHalf_d[acc.wrSel] = acc.wrHi;
      bottomHalf_d[acc.wrSel] = acc.wrLo;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < 4; i++) begin
        upperHalf_q[i] <= ACC_RESET;
        bottomHalf_q[i] <= ACC_RESET;
      end
    end else begin
      for (int i = 0; i < 4; i++) begin
        upperHalf_q[i] <= upperHalf_d[i];
        bottomHalf_q[i] <= bottomHalf_d[i];
      end
    end
  end

  assign acc.rdHi = upperHalf_q[acc.rdSel];
  assign acc.rdLo = bottomHalf_q[acc.rdSel];

endmodule // aeu_acc_bank
`default_nettype wire

// file: hdl/aeu_extract_unit.sv
// word and halfword extraction from an accumulator with shift, round and saturate
//
// What this block does
// - halfword saturating extract decoded, immediate shift field
// - immediate halfword shift taken from instruction field
// - variable shifts use shift source low five bits
// - two-bit select picks accumulator, never modified
// - zero shift: upper, bottom, zero guard bit
// - nonzero shift: sign fill, keep guard bit
// - word overflow checked before and after rounding
// - rounding adds one at guard bit
// - word result bits 32..1, sign-extended
// - positive rounded overflow clamps to Q31 maximum
// - negative rounded overflow clamps, sets flag
// - halfword path shifts accumulator arithmetically
// - halfword flag when sign differs bit 31
// - halfword saturates to 16-bit limits, sign-extends
// - no data-dependent exceptions raised
// - reserved or disabled exception instead of execution
// - plain word extract shares opcode, no rounding
`timescale 1ns/1ps
`default_nettype none
module aeu_extract_unit
  import aeu_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic opValid,
  input wire logic [31:0] opWord,
  input wire logic [63:0] shiftSrcReg,
  input wire logic dspPresent,
  input wire logic dspEnabled,
  input wire logic ovfClear,
  input wire logic accWrEn,
  input wire logic [1:0] accWrSel,
  input wire logic [31:0] accWrHi,
  input wire logic [31:0] accWrLo,
  output logic resValid,
  output logic [63:0] resData,
  output logic [4:0] resDest,
  output logic ovfSetReq,
  output logic ovfSticky,
  output logic excValid,
  output logic excRsvd,
  output logic excDspOff
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // true when the upper 33 bits do not hold a pure sign extension
  function automatic logic wordOverflow(input logic [64:0] t);
    return (t[64:32] != HIGH_ZEROS) && (t[64:32] != HIGH_ONES);
  endfunction

  // {acc,0} shifted arithmetically keeps the guard bit at position 0;
  // a zero count leaves the appended zero as guard
  function automatic logic [64:0] shiftWide(input logic [63:0] a, input logic [4:0] s);
    return 65'($signed({a, 1'b0}) >>> s);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // decode

  aeu_acc_if accBus ();

  aeu_acc_bank uBank (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .acc(accBus)
  );

  aeu_op_t opKind;
  logic varShift;
  logic [4:0] subOp;
  logic ourOp;
  logic [4:0] shiftCount;

  assign subOp = opWord[SUBOP_HI:SUBOP_LO];
  assign ourOp = (opWord[OPC_MAJ_HI:OPC_MAJ_LO] == EXT_MAJOR_OPCODE)
              && (opWord[FUNC_HI:FUNC_LO] == EXT_FUNC_CODE)
              && (opWord[ZERO_HI:ZERO_LO] == ZERO_FIELD);

  always_comb begin
    opKind = AEU_OP_NONE;
    varShift = 1'b0;
    if (ourOp) begin
      if (subOp == SUB_WORD_PLAIN) begin
        opKind = AEU_OP_WORD;
      end else if (subOp == SUB_WORD_RND) begin
        opKind = AEU_OP_WORD_RND;
      end else if (subOp == SUB_WORD_RSAT) begin
        opKind = AEU_OP_WORD_SAT;
      end else if (subOp == SUB_HALF_SAT) begin
        opKind = AEU_OP_HALF;
      end else if (subOp == SUB_WORDV_PLAIN) begin
        opKind = AEU_OP_WORD;
        varShift = 1'b1;
      end else if (subOp == SUB_WORDV_RND) begin
        opKind = AEU_OP_WORD_RND;
        varShift = 1'b1;
      end else if (subOp == SUB_WORDV_RSAT) begin
        opKind = AEU_OP_WORD_SAT;
        varShift = 1'b1;
      end
    end
  end

  // other bits of the shift source register are never looked at
  always_comb begin
    if (varShift) begin
      shiftCount = shiftSrcReg[4:0];
    end else begin
      shiftCount = opWord[SHAMT_HI:SHAMT_LO];
    end
  end

  // the extract path only reads; the write port is passed straight through from the accWr inputs
  assign accBus.rdSel = opWord[ACSEL_HI:ACSEL_LO];
  assign accBus.wrEn = accWrEn;
  assign accBus.wrSel = accWrSel;
  assign accBus.wrHi = accWrHi;
  assign accBus.wrLo = accWrLo;

  logic [63:0] accVal;
  assign accVal = {accBus.rdHi, accBus.rdLo};

  ////////////////////////////////////////////////////////////////////////////
  // word path

  logic [64:0] wTemp;
  logic [64:0] wRound;
  logic wOvfPre;
  logic wOvfPost;
  logic [31:0] wResult;
  logic wFlag;

  always_comb begin
    wTemp = shiftWide(accVal, shiftCount);
    wRound = wTemp + 65'h00000000000000001;
    wOvfPre = wordOverflow(wTemp);
    wOvfPost = wordOverflow(wRound);
    // every word variant records both checks, even the plain one
    wFlag = wOvfPre | wOvfPost;
    case (opKind)
      AEU_OP_WORD_RND: begin
        wResult = wRound[32:1];
      end
      AEU_OP_WORD_SAT: begin
        if (wOvfPost && !wRound[64]) begin
          wResult = Q31_MAX;
        end else if (wOvfPost) begin
          wResult = Q31_MIN;
        end else begin
          wResult = wRound[32:1];
        end
      end
      default: begin
        wResult = wTemp[32:1];
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // halfword path

  logic [63:0] hShift;
  logic hSignFlag;
  logic [31:0] hResult;
  logic hSatFlag;

  always_comb begin
    hShift = 64'($signed(accVal) >>> shiftCount);
    hSignFlag = accVal[63] != hShift[31];
    hSatFlag = 1'b0;
    // compare the full 64-bit signed value against the 16-bit limits
    if ($signed(hShift) > $signed({32'h00000000, HALF_MAX})) begin
      hResult = HALF_MAX;
      hSatFlag = 1'b1;
    end else if ($signed(hShift) < $signed({32'hFFFFFFFF, HALF_MIN})) begin
      hResult = HALF_MIN;
      hSatFlag = 1'b1;
    end else begin
      hResult = hShift[31:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // result and exception registers

  logic accept;
  logic trapRsvd;
  logic trapOff;
  logic [31:0] selResult;
  logic selFlag;

  // exceptions depend only on the extension being present and enabled,
  // never on data values
  assign accept = opValid && (opKind != AEU_OP_NONE);
  assign trapRsvd = accept && !dspPresent;
  assign trapOff = accept && dspPresent && !dspEnabled;

  always_comb begin
    if (opKind == AEU_OP_HALF) begin
      selResult = hResult;
      selFlag = hSignFlag | hSatFlag;
    end else begin
      selResult = wResult;
      selFlag = wFlag;
    end
  end

  logic resValid_q;
  logic resValid_d;
  logic [63:0] resData_q;
  logic [63:0] resData_d;
  logic [4:0] resDest_q;
  logic [4:0] resDest_d;
  logic ovfSetReq_q;
  logic ovfSetReq_d;
  logic excValid_q;
  logic excValid_d;
  logic excRsvd_q;
  logic excRsvd_d;
  logic excDspOff_q;
  logic excDspOff_d;
  logic ovfSticky_q;
  logic ovfSticky_d;

  always_comb begin
    resValid_d = accept && !trapRsvd && !trapOff;
    resData_d = resData_q;
    resDest_d = resDest_q;
    if (resValid_d) begin
      resData_d = {{32{selResult[31]}}, selResult};
      resDest_d = opWord[DEST_HI:DEST_LO];
    end
    ovfSetReq_d = resValid_d && selFlag;
    excValid_d = trapRsvd || trapOff;
    excRsvd_d = trapRsvd;
    excDspOff_d = trapOff;
    // a set arriving with a clear wins, so no overflow event is lost
    if (ovfSetReq_d) begin
      ovfSticky_d = 1'b1;
    end else if (ovfClear) begin
      ovfSticky_d = 1'b0;
    end else begin
      ovfSticky_d = ovfSticky_q;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      resValid_q <= 1'b0;
      resData_q <= RES_RESET;
      resDest_q <= 5'h00;
      ovfSetReq_q <= 1'b0;
      excValid_q <= 1'b0;
      excRsvd_q <= 1'b0;
      excDspOff_q <= 1'b0;
      ovfSticky_q <= 1'b0;
    end else begin
      resValid_q <= resValid_d;
      resData_q <= resData_d;
      resDest_q <= resDest_d;
      ovfSetReq_q <= ovfSetReq_d;
      excValid_q <= excValid_d;
      excRsvd_q <= excRsvd_d;
      excDspOff_q <= excDspOff_d;
      ovfSticky_q <= ovfSticky_d;
    end
  end

  assign resValid = resValid_q;
  assign resData = resData_q;
  assign resDest = resDest_q;
  assign ovfSetReq = ovfSetReq_q;
  assign ovfSticky = ovfSticky_q;
  assign excValid = excValid_q;
  assign excRsvd = excRsvd_q;
  assign excDspOff = excDspOff_q;

endmodule // aeu_extract_unit
`default_nettype wire

// file: verification/aeu_pipe_model.sv
// pipeline side: counts delivered results and keeps its image of the overflow bit
`timescale 1ns/1ps
`default_nettype none
module aeu_pipe_model (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic resValid,
  input wire logic ovfSetReq,
  output logic ctlFlag,
  output logic [15:0] resCount
);
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ctlFlag <= 1'b0;
      resCount <= 16'h0000;
    end else if (resValid) begin
      resCount <= resCount + 16'h0001;
      // the unit may only ever set the bit, never clear it
      ctlFlag <= ctlFlag | ovfSetReq;
    end
  end
endmodule // aeu_pipe_model
`default_nettype wire

// file: verification/aeu_checker_assertions.sv
// port-level property checks for the accumulator extract unit
`timescale 1ns/1ps
`default_nettype none
module aeu_checker
  import aeu_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic opValid,
  input wire logic [31:0] opWord,
  input wire logic dspPresent,
  input wire logic dspEnabled,
  input wire logic ovfClear,
  input wire logic resValid,
  input wire logic [63:0] resData,
  input wire logic [4:0] resDest,
  input wire logic ovfSetReq,
  input wire logic ovfSticky,
  input wire logic excValid,
  input wire logic excRsvd,
  input wire logic excDspOff
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////////////////////////////////////////////
  a_res_cause: assert property (resValid |-> $past(opValid && dspPresent && dspEnabled))
    else $error("result without enabled request");
  a_exc_kind: assert property (excValid |-> $past(opValid) && excRsvd == $past(!dspPresent)
    && excDspOff == $past(dspPresent && !dspEnabled))
    else $error("wrong exception kind");
  a_no_both: assert property (!(resValid && excValid))
    else $error("result and exception together");
  a_dest_field: assert property (resValid |-> resDest == $past(opWord[DEST_HI:DEST_LO]))
    else $error("wrong destination");
  a_sign_ext: assert property (resValid |-> resData[63:32] == {32{resData[31]}})
    else $error("result not sign extended");
  a_half_range: assert property (resValid && $past(opWord[SUBOP_HI:SUBOP_LO]) == SUB_HALF_SAT
    |-> resData[31:15] == {17{resData[31]}})
    else $error("halfword out of range");
  a_set_pair: assert property (ovfSetReq |-> resValid && ovfSticky)
    else $error("flag request unpaired");
  a_clear_works: assert property (ovfClear && !opValid |=> !ovfSticky)
    else $error("clear ignored");
  a_sticky_fall: assert property ($fell(ovfSticky) |-> $past(ovfClear))
    else $error("flag dropped without clear");
  a_res_hold: assert property (!resValid |-> $stable(resData) && $stable(resDest))
    else $error("result changed while idle");
  c_overflow: cover property (resValid && ovfSetReq);
  c_reserved: cover property (excValid && excRsvd);
  c_disabled: cover property (excValid && excDspOff);
endmodule // aeu_checker
bind aeu_extract_unit aeu_checker aeu_checker_i (.sys_clk, .resetn, .opValid, .opWord,
  .dspPresent, .dspEnabled, .ovfClear, .resValid, .resData, .resDest, .ovfSetReq, .ovfSticky,
  .excValid, .excRsvd, .excDspOff);
`default_nettype wire

// file: verification/testbench.sv
// self-checking bench for the accumulator extract unit
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import aeu_pkg::*;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic opValid = 1'b0;
  logic [31:0] opWord = 32'h00000000;
  logic [63:0] shiftSrcReg = 64'h0000000000000000;
  logic dspPresent = 1'b1;
  logic dspEnabled = 1'b1;
  logic ovfClear = 1'b0;
  logic accWrEn = 1'b0;
  logic [1:0] accWrSel = 2'h0;
  logic [31:0] accWrHi = 32'h00000000;
  logic [31:0] accWrLo = 32'h00000000;
  logic resValid, ovfSetReq, ovfSticky, excValid, excRsvd, excDspOff, ctlFlag;
  logic [63:0] resData;
  logic [4:0] resDest;
  logic [15:0] resCount;
  logic expStk = 1'b0;
  int fail_count = 0;
  int check_count = 0;
  logic [4:0] subTab [7] = '{SUB_WORD_PLAIN, SUB_WORD_RND, SUB_WORD_RSAT, SUB_WORDV_PLAIN,
    SUB_WORDV_RND, SUB_WORDV_RSAT, SUB_HALF_SAT};
  logic [63:0] valTab [4] = '{64'h0000000000001234, 64'h00000000FFFFFFFF, 64'hFFFFFFFF80000000,
    64'h8000000000000001};
  logic [4:0] shTab [3] = '{5'h00, 5'h01, 5'h1F};

  aeu_extract_unit aeu_extract_unit_i (.sys_clk, .resetn, .opValid, .opWord, .shiftSrcReg,
    .dspPresent, .dspEnabled, .ovfClear, .accWrEn, .accWrSel, .accWrHi, .accWrLo, .resValid,
    .resData, .resDest, .ovfSetReq, .ovfSticky, .excValid, .excRsvd, .excDspOff);
  aeu_pipe_model aeu_pipe_model_i (.sys_clk, .resetn, .resValid, .ovfSetReq, .ctlFlag,
    .resCount);

  initial begin
    forever #20 sys_clk = ~sys_clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // returns {overflow flag, 32-bit result}
  function automatic logic [32:0] expect_op(logic [63:0] a, logic [4:0] s, logic [4:0] sub);
    logic [64:0] t, u;
    logic [63:0] h;
    logic f;
    t = $signed({a, 1'b0}) >>> s;
    u = t + 65'h1;
    f = (|t[64:32] && !(&t[64:32])) || (|u[64:32] && !(&u[64:32]));
    if (sub inside {SUB_WORD_RND, SUB_WORD_RSAT, SUB_WORDV_RND, SUB_WORDV_RSAT}) t = u;
    if (sub inside {SUB_WORD_RSAT, SUB_WORDV_RSAT} && |u[64:32] && !(&u[64:32])) begin
      t[32:1] = u[64] ? Q31_MIN : Q31_MAX;
    end
    if (sub != SUB_HALF_SAT) return {f, t[32:1]};
    h = $signed(a) >>> s;
    f = a[63] != h[31];
    if ($signed(h) > $signed({32'h00000000, HALF_MAX})) begin
      h = {32'h00000000, HALF_MAX};
      f = 1'b1;
    end else if ($signed(h) < $signed({32'hFFFFFFFF, HALF_MIN})) begin
      h = {32'hFFFFFFFF, HALF_MIN};
      f = 1'b1;
    end
    return {f, h[31:0]};
  endfunction

  task automatic chk(string what, logic [63:0] exp, logic [63:0] got);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic wacc(logic [1:0] sel, logic [63:0] v);
    @(posedge sys_clk);
    accWrEn <= 1'b1;
    accWrSel <= sel;
    {accWrHi, accWrLo} <= v;
    @(posedge sys_clk);
    accWrEn <= 1'b0;
  endtask

  // one request; returns just after the answering edge
  task automatic issue(logic [4:0] sub, logic [4:0] fld, logic [1:0] sel, logic [63:0] rsv);
    @(posedge sys_clk);
    opValid <= 1'b1;
    opWord <= {EXT_MAJOR_OPCODE, fld, 5'h0B, ZERO_FIELD, sel, sub, EXT_FUNC_CODE};
    shiftSrcReg <= rsv;
    @(posedge sys_clk);
    opValid <= 1'b0;
    #1;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_extract();
    logic [32:0] e;
    logic [4:0] sb;
    for (int j = 0; j < 4; j++) wacc(2'(j), valTab[j]);
    for (int j = 0; j < 4; j++)
      for (int k = 0; k < 3; k++)
        for (int m = 0; m < 7; m++) begin
          sb = subTab[m];
          e = expect_op(valTab[j], shTab[k], sb);
          // the unused shift source gets the inverted count; the shift source register always has ones above bit 4
          issue(sb, sb[0] ? ~shTab[k] : shTab[k], 2'(j), {~59'h0, sb[0] ? shTab[k] : ~shTab[k]});
          chk("valid", 64'h1, 64'(resValid));
          chk("data", {{32{e[31]}}, e[31:0]}, resData);
          chk("dest", 64'h0B, 64'(resDest));
          chk("setreq", 64'(e[32]), 64'(ovfSetReq));
          expStk = expStk | e[32];
          chk("sticky", 64'(expStk), 64'(ovfSticky));
        end
    $display("test extract done");
  endtask

  task automatic t_exc();
    for (int c = 0; c < 3; c++) begin
      dspPresent <= (c == 2);
      dspEnabled <= (c == 0);
      issue(SUB_WORD_RND, 5'h01, 2'h1, 64'h0);
      chk("exception", 64'h1, 64'(excValid));
      chk("reserved", 64'(c != 2), 64'(excRsvd));
      chk("disabled", 64'(c == 2), 64'(excDspOff));
      chk("no result", 64'h0, 64'(resValid));
    end
    dspPresent <= 1'b1;
    dspEnabled <= 1'b1;
    issue(5'h0F, 5'h01, 2'h1, 64'h0);
    chk("ignored", 64'h0, 64'({resValid, excValid}));
    $display("test exceptions done");
  endtask

  // a write at the taking edge must not be seen by that request, only by the next
  task automatic t_b2b();
    logic [32:0] e0, e1;
    e0 = expect_op(valTab[3], 5'h04, SUB_WORD_PLAIN);
    e1 = expect_op(64'h0000000012345678, 5'h04, SUB_WORD_PLAIN);
    @(posedge sys_clk);
    opValid <= 1'b1;
    opWord <= {EXT_MAJOR_OPCODE, 5'h04, 5'h0B, ZERO_FIELD, 2'h3, SUB_WORD_PLAIN, EXT_FUNC_CODE};
    accWrEn <= 1'b1;
    accWrSel <= 2'h3;
    {accWrHi, accWrLo} <= 64'h0000000012345678;
    @(posedge sys_clk);
    accWrEn <= 1'b0;
    #1;
    chk("first", {{32{e0[31]}}, e0[31:0]}, resData);
    @(posedge sys_clk);
    opValid <= 1'b0;
    #1;
    chk("second", {{32{e1[31]}}, e1[31:0]}, resData);
    chk("second valid", 64'h1, 64'(resValid));
    // the pipeline counts a result at the edge after it appears
    @(posedge sys_clk);
    #1;
    chk("delivered", 64'(4 * 3 * 7 + 2), 64'(resCount));
    $display("test back to back done");
  endtask

  task automatic t_sticky();
    @(posedge sys_clk);
    ovfClear <= 1'b1;
    @(posedge sys_clk);
    ovfClear <= 1'b0;
    #1;
    chk("cleared", 64'h0, 64'(ovfSticky));
    chk("pipe flag", 64'h1, 64'(ctlFlag));
    ovfClear <= 1'b1;
    issue(SUB_WORD_PLAIN, 5'h00, 2'h1, 64'h0);
    chk("set wins", 64'h3, 64'({ovfSetReq, ovfSticky}));
    ovfClear <= 1'b0;
    $display("test sticky done");
  endtask

  initial begin
    repeat (16) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    #1;
    chk("reset", 64'h0, resData | 64'({resValid, ovfSticky, excValid}));
    t_extract();
    t_exc();
    t_b2b();
    t_sticky();
    conclude();
  end

  initial begin
    repeat (5000) @(posedge sys_clk);
    fail_count++;
    conclude();
  end
endmodule // testbench
`default_nettype wire
